// [core/dma_pkg.sv]
// constants, field layout and carrier types of one dma channel
// assumes a 32-bit apb slave port and an 8-bit word-aligned register window
package dma_pkg;

   localparam int unsigned AW    = 8;
   localparam int unsigned DW    = 32;
   localparam int unsigned CW    = 16;
   localparam int unsigned EVT_N = 32;
   localparam int unsigned FDEP  = 8;

   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
   localparam logic [AW-1:0] OFS_IDX_A   = 8'h04;
   localparam logic [AW-1:0] OFS_IDX_B   = 8'h08;
   localparam logic [AW-1:0] OFS_RLD_A   = 8'h0C;
   localparam logic [AW-1:0] OFS_RLD_B   = 8'h10;
   localparam logic [AW-1:0] OFS_GADDR_A = 8'h14;
   localparam logic [AW-1:0] OFS_GADDR_B = 8'h18;
   localparam logic [AW-1:0] OFS_GADDR_C = 8'h1C;
   localparam logic [AW-1:0] OFS_SRC     = 8'h20;
   localparam logic [AW-1:0] OFS_DST     = 8'h24;
   localparam logic [AW-1:0] OFS_COUNT   = 8'h28;

   // read-sync event codes
   localparam logic [4:0] EVT_NONE        = 5'h00;
   localparam logic [4:0] EVT_CH3_DONE    = 5'h0B;
   localparam logic [4:0] EVT_SP0_TX      = 5'h0C;
   localparam logic [4:0] EVT_SP0_RX      = 5'h0D;
   localparam logic [4:0] EVT_SP1_TX      = 5'h0E;
   localparam logic [4:0] EVT_SP1_RX      = 5'h0F;
   localparam logic [4:0] EVT_HOST        = 5'h10;
   localparam logic [4:0] EVT_SP2_TX      = 5'h11;
   localparam logic [4:0] EVT_SP2_RX      = 5'h12;
   localparam logic [4:0] EVT_RSV_FIRST   = 5'h13;

   localparam logic [1:0] ESZ_32 = 2'h0;
   localparam logic [1:0] ESZ_16 = 2'h1;
   localparam logic [1:0] ESZ_8  = 2'h2;

   localparam logic [DW-1:0] STEP_32 = 32'h0000_0004;
   localparam logic [DW-1:0] STEP_16 = 32'h0000_0002;
   localparam logic [DW-1:0] STEP_8  = 32'h0000_0001;
   localparam logic [DW-1:0] STEP_0  = 32'h0000_0000;

   localparam logic [1:0] UPD_KEEP = 2'h0;
   localparam logic [1:0] UPD_INC  = 2'h1;
   localparam logic [1:0] UPD_DEC  = 2'h2;
   localparam logic [1:0] UPD_IDX  = 2'h3;

   localparam logic [1:0] ST_STOPPED   = 2'h0;
   localparam logic [1:0] ST_RUNNING   = 2'h1;
   localparam logic [1:0] ST_PAUSED    = 2'h2;
   localparam logic [1:0] ST_RUN_RLD   = 2'h3;

   localparam logic [1:0] CMD_STOP     = 2'h0;
   localparam logic [1:0] CMD_START    = 2'h1;
   localparam logic [1:0] CMD_PAUSE    = 2'h2;
   localparam logic [1:0] CMD_START_RLD = 2'h3;

   localparam logic [1:0] SPLIT_OFF = 2'h0;
   localparam logic [1:0] SPLIT_A   = 2'h1;
   localparam logic [1:0] SPLIT_B   = 2'h2;

   typedef struct packed {
      logic [12:0] upper;
      logic [4:0]  read_sync_event_select;
      logic        index_sel;
      logic        count_reload_select;
      logic [1:0]  split_sel;
      logic [1:0]  element_width_select;
      logic [1:0]  dest_addr_update_mode;
      logic [1:0]  src_addr_update_mode;
      logic [1:0]  status;
      logic [1:0]  start;
   } ctrl_t;

   localparam ctrl_t       CTRL_RESET  = '0;
   localparam logic [DW-1:0] WORD_RESET = 32'h0000_0000;
   localparam logic [CW-1:0] COUNT_ZERO = 16'h0000;
   localparam logic [CW-1:0] COUNT_ONE  = 16'h0001;

   typedef struct packed {
      logic          req;
      logic [DW-1:0] addr;
      logic [1:0]    size;
   } rd_req_t;

   typedef struct packed {
      logic          req;
      logic [DW-1:0] addr;
      logic [DW-1:0] data;
      logic [1:0]    size;
   } wr_req_t;

   typedef enum logic {RD_IDLE, RD_WAIT} rd_ph_t;

   function automatic logic [DW-1:0] step_bytes(input logic [1:0] esz);
      case (esz)
         ESZ_32:  step_bytes = STEP_32;
         ESZ_16:  step_bytes = STEP_16;
         ESZ_8:   step_bytes = STEP_8;
         default: step_bytes = STEP_0;
      endcase
   endfunction : step_bytes

   function automatic logic [DW-1:0] next_addr(input logic [DW-1:0] a,
                                              input logic [1:0]    mode,
                                              input logic [1:0]    esz,
                                              input logic [DW-1:0] idx);
      case (mode)
         UPD_INC: next_addr = a + step_bytes(esz);
         UPD_DEC: next_addr = a - step_bytes(esz);
         UPD_IDX: next_addr = a + idx;
         default: next_addr = a;
      endcase
   endfunction : next_addr

endpackage : dma_pkg

// [core/stream_fifo.sv]
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [PW:0]                 cnt;
   } fifo_st_t;

   fifo_st_t q;
   fifo_st_t d;
   logic     push;
   logic     pop;

   assign in_ready  = q.cnt != (PW+1)'(DEPTH);
   assign out_valid = q.cnt != '0;
   assign out_data  = q.mem[q.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = in_data;
         d.wp        = q.wp + PW'(1);
      end
      if (pop)
         d.rp = q.rp + PW'(1);
      // pointers wrap naturally since depth is a power of two
      d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
      if (flush)
      begin
         d.wp  = '0;
         d.rp  = '0;
         d.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else if (ce)
         q <= d;
   end
endmodule : stream_fifo
`default_nettype wire

// [core/dma_channel.sv]
// one dma channel: apb register file, read engine, fifo, write engine
// assumes memory ports on pclk; event lines are asynchronous pins
`timescale 1ns/1ps
`default_nettype none

// Contract
// - codes Bh..Fh select ch3 and serial events
// - codes 10h..12h map; 13h-1Fh reserved
// - bit 13 picks index register A/B
// - bit 12 picks count reload A/B
// - split field picks address A/B/C or off
// - element size 32/16/8 bits, byte steps
// - destination keep/inc/dec/index after element
// - source keep/inc/dec/index after element
// - decrement by element size in bytes
// - index mode uses currently selected index
// - status: stopped, running, paused, running_with_reload
module dma_channel
   import dma_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [AW-1:0]    paddr,
   input  wire logic [DW-1:0]    pwdata,
   output logic [DW-1:0]         prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [EVT_N-1:0] event_lines,
   output rd_req_t               rd_out,
   input  wire logic             rd_valid,
   input  wire logic [DW-1:0]    rd_data,
   output wr_req_t               wr_out,
   input  wire logic             wr_ack,
   output logic                  split_en,
   output logic [DW-1:0]         split_addr
);

   typedef struct packed {
      ctrl_t            ctrl;
      logic [DW-1:0]    idx_a;
      logic [DW-1:0]    idx_b;
      logic [DW-1:0]    rld_a;
      logic [DW-1:0]    rld_b;
      logic [DW-1:0]    gaddr_a;
      logic [DW-1:0]    gaddr_b;
      logic [DW-1:0]    gaddr_c;
      logic [DW-1:0]    src;
      logic [DW-1:0]    dst;
      logic [CW-1:0]    count;
      rd_ph_t           rd_ph;
      logic             pready;
      logic             pslverr;
      logic [DW-1:0]    prdata;
      rd_req_t          rd;
      wr_req_t          wr;
      logic             split_en;
      logic [DW-1:0]    split_addr;
      logic [EVT_N-1:0] s1;
      logic [EVT_N-1:0] s2;
      logic [EVT_N-1:0] s3;
      logic [EVT_N-1:0] lvl;
      logic             pend;
   } chan_st_t;

   chan_st_t q;
   chan_st_t d;

   logic          f_in_valid;
   logic          f_in_ready;
   logic          f_out_valid;
   logic          f_out_ready;
   logic [DW-1:0] f_out_data;
   logic          f_flush;

   assign prdata     = q.prdata;
   assign pready     = q.pready;
   assign pslverr    = q.pslverr;
   assign rd_out     = q.rd;
   assign wr_out     = q.wr;
   assign split_en   = q.split_en;
   assign split_addr = q.split_addr;

   logic running;
   logic wr_commit;
   logic cmd_write;
   logic issue_rd;
   logic pop_wr;
   logic done;
   logic ev_hit;
   logic [EVT_N-1:0] agree;
   logic [EVT_N-1:0] rise;
   logic [DW-1:0]    idx_sel;

   assign running = (q.ctrl.status == ST_RUNNING) | (q.ctrl.status == ST_RUN_RLD);
   // writes land on the edge that also samples pready high
   assign wr_commit = psel & penable & pwrite & q.pready;
   assign cmd_write = wr_commit & (paddr == OFS_CTRL);

   // only s2/s3 feed logic; s1 is read by s2 alone
   assign agree = ~(q.s2 ^ q.s3);
   assign rise  = q.s2 & agree & ~q.lvl;

   assign ev_hit = (q.ctrl.read_sync_event_select < EVT_RSV_FIRST) &
                   rise[q.ctrl.read_sync_event_select];

   assign idx_sel = q.ctrl.index_sel ? q.idx_b : q.idx_a;

   // one read outstanding; fifo space checked before issue
   assign issue_rd = running & (q.rd_ph == RD_IDLE) & (q.count != COUNT_ZERO) &
                     f_in_ready &
                     ((q.ctrl.read_sync_event_select == EVT_NONE) | q.pend);
   assign f_in_valid  = rd_valid & (q.rd_ph == RD_WAIT);
   assign f_out_ready = running & ~q.wr.req;
   assign pop_wr      = f_out_valid & f_out_ready;
   assign done = running & (q.count == COUNT_ZERO) & (q.rd_ph == RD_IDLE) &
                 ~f_out_valid & ~q.wr.req;
   assign f_flush = cmd_write & (pwdata[1:0] == CMD_STOP);

   always_comb
   begin
      d = q;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      d.rd.req  = 1'b0;

      // read data captured in the first access cycle
      if (psel & penable & ~q.pready)
      begin
         d.pready  = 1'b1;
         d.prdata  = WORD_RESET;
         case (paddr)
            OFS_CTRL:    d.prdata = q.ctrl;
            OFS_IDX_A:   d.prdata = q.idx_a;
            OFS_IDX_B:   d.prdata = q.idx_b;
            OFS_RLD_A:   d.prdata = q.rld_a;
            OFS_RLD_B:   d.prdata = q.rld_b;
            OFS_GADDR_A: d.prdata = q.gaddr_a;
            OFS_GADDR_B: d.prdata = q.gaddr_b;
            OFS_GADDR_C: d.prdata = q.gaddr_c;
            OFS_SRC:     d.prdata = q.src;
            OFS_DST:     d.prdata = q.dst;
            OFS_COUNT:   d.prdata = {{(DW-CW){1'b0}}, q.count};
            default:     d.pslverr = 1'b1;
         endcase
      end

      if (wr_commit)
      begin
         case (paddr)
            OFS_CTRL:    d.ctrl        = ctrl_t'(pwdata);
            OFS_IDX_A:   d.idx_a       = pwdata;
            OFS_IDX_B:   d.idx_b       = pwdata;
            OFS_RLD_A:   d.rld_a       = pwdata;
            OFS_RLD_B:   d.rld_b       = pwdata;
            OFS_GADDR_A: d.gaddr_a     = pwdata;
            OFS_GADDR_B: d.gaddr_b     = pwdata;
            OFS_GADDR_C: d.gaddr_c     = pwdata;
            OFS_SRC:     d.src         = pwdata;
            OFS_DST:     d.dst         = pwdata;
            OFS_COUNT:   d.count       = pwdata[CW-1:0];
            default:     d.ctrl        = q.ctrl;
         endcase
         // status bits are read-only to software
         d.ctrl.status = q.ctrl.status;
      end

      // event synchroniser: a change counts once s2 and s3 agree
      d.s1  = event_lines;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.lvl = (q.lvl & ~agree) | (q.s2 & agree);

      // read engine
      if (issue_rd)
      begin
         d.rd.req  = 1'b1;
         d.rd.addr = q.src;
         d.rd.size = q.ctrl.element_width_select;
         d.rd_ph   = RD_WAIT;
         d.count   = q.count - COUNT_ONE;
         d.src = next_addr(q.src, q.ctrl.src_addr_update_mode,
                           q.ctrl.element_width_select, idx_sel);
      end
      if (f_in_valid)
         d.rd_ph = RD_IDLE;

      // pending event: a new event beats the consuming clear
      d.pend = (q.pend & ~issue_rd) | ev_hit;

      // write engine
      if (q.wr.req & wr_ack)
         d.wr.req = 1'b0;
      if (pop_wr)
      begin
         d.wr.req  = 1'b1;
         d.wr.addr = q.dst;
         d.wr.data = f_out_data;
         d.wr.size = q.ctrl.element_width_select;
         d.dst = next_addr(q.dst, q.ctrl.dest_addr_update_mode,
                           q.ctrl.element_width_select, idx_sel);
      end

      // end of block: reload or stop
      if (done)
      begin
         if (q.ctrl.status == ST_RUN_RLD)
            d.count = q.ctrl.count_reload_select ? q.rld_b[CW-1:0] : q.rld_a[CW-1:0];
         else
            d.ctrl.status = ST_STOPPED;
      end

      if (cmd_write)
      begin
         case (pwdata[1:0])
            CMD_START:     d.ctrl.status = ST_RUNNING;
            CMD_PAUSE:     d.ctrl.status = ST_PAUSED;
            CMD_START_RLD: d.ctrl.status = ST_RUN_RLD;
            default:
            begin
               // stop aborts: in-flight read and write are dropped
               d.ctrl.status = ST_STOPPED;
               d.rd_ph       = RD_IDLE;
               d.wr.req      = 1'b0;
               d.pend        = 1'b0;
            end
         endcase
      end

      d.split_en = d.ctrl.split_sel != SPLIT_OFF;
      case (d.ctrl.split_sel)
         SPLIT_A: d.split_addr = q.gaddr_a;
         SPLIT_B: d.split_addr = q.gaddr_b;
         default: d.split_addr = q.gaddr_c;
      endcase
   end

   // reserved size gives a zero step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q      <= '0;
         q.ctrl <= CTRL_RESET;
      end
      else if (ce)
         q <= d;
   end

   stream_fifo #(
      .WIDTH (DW),
      .DEPTH (FDEP)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .ce        (ce),
      .flush     (f_flush),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (rd_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

endmodule : dma_channel
`default_nettype wire

// [dv/dma_channel_monitor.sv]
// port assertions for one dma channel
// assumes a bind from the bench and a single pclk domain
`timescale 1ns/1ps
`default_nettype none
module dma_channel_monitor
   import dma_pkg::*;
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [DW-1:0] pwdata,
   input wire logic [DW-1:0] prdata,
   input wire logic          pready,
   input wire rd_req_t       rd_out,
   input wire wr_req_t       wr_out,
   input wire logic          wr_ack,
   input wire logic          split_en
);
   wire logic wacc = psel && penable && pready && pwrite;
   wire logic wrise;
   logic [DW-1:0] ctl_q, ia_q, ib_q, ra_q, wa_q;
   logic [3:0]    idle_q;
   logic          rv_q, wv_q, wp_q;
   assign wrise = wr_out.req && !wp_q;

   function automatic logic [DW-1:0] nxt(input logic [DW-1:0] a, input logic [1:0] m,
                                         input logic [1:0] e, input logic [DW-1:0] x);
      logic [DW-1:0] s;
      s = e == ESZ_32 ? STEP_32 : (e == ESZ_16 ? STEP_16 : STEP_8);
      nxt = m == UPD_INC ? a + s : (m == UPD_DEC ? a - s : (m == UPD_IDX ? a + x : a));
   endfunction : nxt

   // address chains restart whenever software writes anything
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {ctl_q, ia_q, ib_q, ra_q, wa_q} <= '0;
         {idle_q, rv_q, wv_q, wp_q} <= '0;
      end
      else
      begin
         idle_q <= wacc ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
         rv_q   <= !wacc && (rv_q || rd_out.req);
         wv_q   <= !wacc && (wv_q || wrise);
         wp_q   <= wr_out.req;
         ra_q   <= rd_out.req ? rd_out.addr : ra_q;
         wa_q   <= wrise ? wr_out.addr : wa_q;
         ctl_q  <= wacc && paddr == OFS_CTRL ? pwdata : ctl_q;
         ia_q   <= wacc && paddr == OFS_IDX_A ? pwdata : ia_q;
         ib_q   <= wacc && paddr == OFS_IDX_B ? pwdata : ib_q;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   src_step_a:
      assert property (rd_out.req && rv_q |-> rd_out.addr ==
         nxt(ra_q, ctl_q[5:4], ctl_q[9:8], ctl_q[13] ? ib_q : ia_q))
      else $error("source address step wrong");
   dst_step_a:
      assert property (wrise && wv_q |-> wr_out.addr ==
         nxt(wa_q, ctl_q[7:6], ctl_q[9:8], ctl_q[13] ? ib_q : ia_q))
      else $error("destination address step wrong");
   read_size_a:
      assert property (rd_out.req && idle_q > 4'h2 |-> rd_out.size == ctl_q[9:8])
      else $error("read element size wrong");
   split_on_a:
      assert property (idle_q > 4'h3 |-> split_en == (ctl_q[11:10] != SPLIT_OFF))
      else $error("split enable wrong");
   pause_hold_a:
      assert property (ctl_q[1:0] == CMD_PAUSE && idle_q > 4'h1 |-> !rd_out.req && !wrise)
      else $error("transfer issued while paused");
   stop_quiet_a:
      assert property (ctl_q[1:0] == CMD_STOP && idle_q > 4'h2 |-> !rd_out.req && !wr_out.req)
      else $error("transfer issued while stopped");
   status_read_a:
      assert property (psel && penable && pready && !pwrite && paddr == OFS_CTRL &&
         ctl_q[1:0] != CMD_START |-> prdata[3:2] == ctl_q[1:0])
      else $error("status does not follow command");
   write_hold_a:
      assert property (wr_out.req && !wr_ack && !(psel && pwrite) |=>
         wr_out.req && $stable(wr_out.addr) && $stable(wr_out.data))
      else $error("write request dropped before ack");
endmodule : dma_channel_monitor
`default_nettype wire

// [dv/dma_mem_model.sv]
// memory side answering the channel read and write ports
// assumes one read outstanding; slow stretches both answers
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model
   import dma_pkg::*;
(
   input  wire logic     pclk,
   input  wire logic     presetn,
   input  wire logic     slow,
   input  wire rd_req_t  rd_out,
   output logic          rd_valid,
   output logic [DW-1:0] rd_data,
   input  wire wr_req_t  wr_out,
   output logic          wr_ack
);
   logic [DW-1:0] mem [logic [DW-1:0]];
   logic [DW-1:0] ra;
   int            rw, ww;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_valid <= 1'b0;
         wr_ack   <= 1'b0;
         rd_data  <= 32'h0000_0000;
         rw = 0;
         ww = 0;
      end
      else
      begin
         rd_valid <= rw == 1;
         // bus toggles between answers so stale data never looks valid
         rd_data  <= rw == 1 ? (mem.exists(ra) ? mem[ra] : ~ra) : ~rd_data;
         rw = rw > 0 ? rw - 1 : 0;
         if (rd_out.req)
         begin
            ra = rd_out.addr;
            rw = slow ? 4 : 2;
         end
         wr_ack <= wr_out.req && !wr_ack && ww >= (slow ? 3 : 0);
         if (wr_out.req && !wr_ack && ww >= (slow ? 3 : 0))
            mem[wr_out.addr] = wr_out.data;
         ww = wr_out.req && !wr_ack ? ww + 1 : 0;
      end
   end
endmodule : dma_mem_model
`default_nettype wire

// [dv/tb_top.sv]
// register-driven tests of one dma channel over apb
// assumes dma_mem_model on the memory ports and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dma_pkg::*;
   logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic             rd_valid, wr_ack, split_en, slow, e;
   logic [AW-1:0]    paddr;
   logic [DW-1:0]    pwdata, prdata, rd_data, split_addr, r, la_r, ld_w;
   logic [EVT_N-1:0] event_lines;
   rd_req_t          rd_out;
   wr_req_t          wr_out;
   int               errors, check_count, nrd, nwr, cyc, n0, r0;

   dma_channel u_dma_channel (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .event_lines, .rd_out, .rd_valid, .rd_data,
      .wr_out, .wr_ack, .split_en, .split_addr);
   dma_mem_model u_dma_mem_model (.pclk, .presetn, .slow, .rd_out, .rd_valid, .rd_data,
      .wr_out, .wr_ack);

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // counted mid-cycle so registered outputs are settled when looked at
   always @(negedge pclk)
   begin
      cyc++;
      if (rd_out.req)
      begin
         nrd++;
         la_r = rd_out.addr;
      end
      if (wr_out.req && wr_ack)
      begin
         nwr++;
         ld_w = wr_out.data;
      end
      if (cyc == 40000)
      begin
         errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string nm);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is a one-cycle pulse: find it settled, then pass the edge that samples it
      do @(negedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic idle_wait();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, OFS_CTRL, 32'h0000_0000);
         n++;
      end
      while (r[3:2] !== ST_STOPPED && n < 100);
   endtask : idle_wait

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   initial
   begin
      {presetn, ce, psel, penable, pwrite, slow, paddr, pwdata, event_lines} = '0;
      {errors, check_count, nrd, nwr, cyc} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      ce      <= 1'b1;
      // offset 0x2c is unmapped and must be refused
      for (int a = 0; a < 12; a++)
      begin
         apb(1'b0, AW'(a * 4), 32'h0000_0000);
         chk({e, r[30:0]}, {a == 11, 31'h0}, "reset word");
      end
      $display("test reset done");
      for (int i = 0; i < 3; i++)
         apb(1'b1, AW'(OFS_GADDR_A + 4 * i), DW'(32'h1000_0000 * (i + 1)));
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, OFS_CTRL, DW'(s << 10));
         repeat (4) @(posedge pclk);
         chk(split_en ? split_addr : 32'h0, DW'(32'h1000_0000 * s), "split address");
      end
      $display("test split done");
      apb(1'b1, OFS_IDX_A, 32'h0000_0008);
      apb(1'b1, OFS_IDX_B, 32'hFFFF_FFFC);
      for (int k = 0; k < 12; k++)
      begin
         slow <= k[0];
         n0 = nwr;
         apb(1'b1, OFS_SRC, 32'h0000_0400);
         apb(1'b1, OFS_DST, 32'h0000_0800);
         apb(1'b1, OFS_COUNT, 32'h0000_0003);
         // legal start with a legal size
         apb(1'b1, OFS_CTRL, DW'((k % 2) << 13 | (k % 3) << 8 | ((k + 1) % 4) << 6 | (k % 4) << 4 | 1));
         idle_wait();
         chk(DW'(nwr - n0), 32'h0000_0003, "elements moved");
         chk(ld_w, ~la_r, "last element data");
      end
      $display("test transfer modes done");
      for (int c = 'h0B; c <= 'h13; c++)
      begin
         r0 = nrd;
         apb(1'b1, OFS_COUNT, 32'h0000_0001);
         apb(1'b1, OFS_CTRL, DW'(c << 14 | 1));
         repeat (10) @(posedge pclk);
         chk(DW'(nrd - r0), 32'h0000_0000, "read before event");
         event_lines[c] <= 1'b1;
         repeat (12) @(posedge pclk);
         event_lines[c] <= 1'b0;
         chk(DW'(nrd - r0), DW'(c < 'h13), "read after event");
         apb(1'b1, OFS_CTRL, 32'h0000_0000);
      end
      $display("test sync events done");
      apb(1'b1, OFS_RLD_A, 32'h0000_0000);
      apb(1'b1, OFS_RLD_B, 32'h0000_0002);
      for (int b = 1; b >= 0; b--)
      begin
         n0 = nwr;
         apb(1'b1, OFS_COUNT, 32'h0000_0001);
         apb(1'b1, OFS_CTRL, DW'(b << 12 | 3));
         repeat (40) @(posedge pclk);
         apb(1'b0, OFS_CTRL, 32'h0000_0000);
         chk(DW'(r[3:2]), DW'(ST_RUN_RLD), "status with reload");
         chk(DW'(nwr - n0 == 1), DW'(b == 0), "reload source");
         apb(1'b1, OFS_CTRL, DW'(CMD_PAUSE));
         apb(1'b0, OFS_CTRL, 32'h0000_0000);
         chk(DW'(r[3:2]), DW'(ST_PAUSED), "status paused");
         apb(1'b1, OFS_CTRL, DW'(CMD_STOP));
         apb(1'b0, OFS_CTRL, 32'h0000_0000);
         chk(DW'(r[3:2]), DW'(ST_STOPPED), "status stopped");
      end
      $display("test reload and commands done");
      complete_run();
   end
endmodule : tb_top

bind dma_channel dma_channel_monitor u_dma_channel_monitor (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .rd_out, .wr_out, .wr_ack, .split_en);
`default_nettype wire
